// ### shared/e1tz_pkg.sv
// Shared constants and types for the timeslot zero framer
package e1tz_pkg;
	// ****************************************************************
	// Synchroniser lane positions for pins from outside the clock domain
	// ****************************************************************
	localparam int P_SCAN = 0;
	localparam int P_TCLK = 1;
	localparam int P_FRS = 2;
	localparam int P_D1N = 3;
	localparam int P_D1S = 4;
	localparam int P_RCLK = 5;
	localparam int P_RD = 6;
	localparam int P_RRST = 7;
	localparam int P_CRC = 8;
	localparam int P_F13 = 9;
	localparam int P_F15 = 10;
	localparam int PIN_N = 11;

	// ****************************************************************
	// Frame geometry
	// ****************************************************************
	localparam logic [3:0] BIT_FIRST = 4'h1;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [4:0] TS_ZERO = 5'h00;
	localparam logic [4:0] TS_ONE = 5'h01;
	localparam logic [4:0] TS_MID = 5'h10;
	localparam logic [4:0] TS_LAST = 5'h1F;
	localparam logic [6:0] FAS_WORD = 7'h1B;
	localparam logic [1:0] BAD_LIMIT = 2'h3;
	localparam int USER_W = 6;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic CCR_IDLE = 1'b1;
	localparam logic TS0_RST = 1'b1; // Counters restart inside TS0, so the marker starts high
	localparam logic CK8_RST = 1'b1;
	localparam logic SYNC_FR_RST = 1'b1;

	// Receiver alignment state
	typedef enum logic [1:0] {
		ST_OUT = 2'b01,
		ST_IN = 2'b10
	} e1tz_sync_t;
endpackage : e1tz_pkg

// ### logic/e1tz_rx_alarm.sv
// Remote alarm persistence check for the timeslot zero receiver
`timescale 1ns/1ps
module e1tz_rx_alarm
	import e1tz_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_upd,
	input wire logic i_bit3,
	input wire logic i_in_sync,
	output logic o_rx_remote_alarm
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic prev;
		logic rx_remote_alarm;
	} e1tz_rai_t;

	e1tz_rai_t r;
	e1tz_rai_t next_r;

	// Update once per non-sync frame boundary
	always_comb begin
		next_r = r;
		if (i_upd) begin
			if (!i_in_sync) begin
				next_r.rx_remote_alarm = 1'b0;
				next_r.prev = 1'b0;
			end else begin
				if (i_bit3 && r.prev) begin
					next_r.rx_remote_alarm = 1'b1;
				end else if (!i_bit3 && !r.prev) begin
					next_r.rx_remote_alarm = 1'b0;
				end
				next_r.prev = i_bit3;
			end
		end
	end

	// Register with synchronous reset
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			r <= '0;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_rx_remote_alarm = r.rx_remote_alarm;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	property p_rai_edge;
		$changed(o_rx_remote_alarm) |-> $past(i_upd) && $past(i_ce);
	endproperty
	a_rai_edge: assert property (p_rai_edge) else $error("alarm moved off boundary");

	property p_rai_rise;
		$rose(o_rx_remote_alarm) |-> $past(i_bit3) && $past(r.prev) && $past(i_in_sync);
	endproperty
	a_rai_rise: assert property (p_rai_rise) else $error("alarm rose without two highs");

	property p_rai_low;
		i_upd && i_ce && !i_in_sync |=> !o_rx_remote_alarm;
	endproperty
	a_rai_low: assert property (p_rai_low) else $error("alarm not forced low");
endmodule : e1tz_rx_alarm

// ### logic/e1tz_framer.sv
// Timeslot zero transmit and receive timing, international bits and alarms
//
// Operation
// - Non-sync frames send the non-sync international input in bit 1 of TS0.
// - Sync frames send the sync international input in bit 1 of TS0.
// - Sync frame marker toggles after bit 1 of TS1, high in sync TS0.
// - TS0 marker is high for the eight bit periods of TS0 only.
// - Scan select high enters scan mode; outside logic keeps it low normally.
// - Channel reset strobe is low one period in bit 1 TS1 of sync frames.
// - 8 kHz clock falls at bit 8 of TS0, rises at bit 8 TS16.
// - In sync, two consecutive high bit 3 values raise the remote alarm.
// - Remote alarm changes only at bit 1 TS1 of non-sync frames.
// - After losing sync the remote alarm is forced low until sync returns.
// - Bits count 1 to 8, timeslots 0 to 31, frames alternate.
// - Checksum mode lets frame 13 and 15 markers steer international bits.
// - User bits 3 to 8 of non-sync TS0 update half a period after TS0.
// - Three consecutive bad alignment words while in sync drop sync.
`timescale 1ns/1ps
module e1tz_framer
	import e1tz_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_scan_test_select,
	input wire logic i_tx_bit_clk,
	input wire logic i_tx_frame_sync_in,
	input wire logic i_tx_intl_bit_nonsync_in,
	input wire logic i_tx_intl_bit_sync_in,
	input wire logic i_rx_bit_clk,
	input wire logic i_rx_data,
	input wire logic i_rx_reset,
	input wire logic i_rx_crc_mode,
	input wire logic i_rx_frame13_marker,
	input wire logic i_rx_frame15_marker,
	input wire logic i_rx_align_found,
	output logic o_scan_mode,
	output logic o_tx_data,
	output logic o_tx_sync_frame_marker,
	output logic o_rx_ts0_marker,
	output logic o_rx_channel_reset_strobe_n,
	output logic o_rx_eight_khz_clock,
	output logic o_rx_intl_bit_nonsync,
	output logic o_rx_intl_bit_sync,
	output logic [USER_W-1:0] o_rx_user_bits,
	output logic o_rx_sync_word_error,
	output logic o_rx_in_sync,
	output logic o_rx_remote_alarm
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic [PIN_N-1:0] s3;
		logic [3:0] tx_bit;
		logic [4:0] tx_ts;
		logic tx_active;
		logic tx_marker;
		logic tx_data;
		logic [3:0] rx_bit;
		logic [4:0] rx_ts;
		logic rx_sync_fr;
		logic [6:0] rx_shift;
		logic [7:0] rx_word;
		logic rx_f13;
		logic rx_f15;
		logic ts0;
		logic ccr_n;
		logic ck8;
		logic q1n;
		logic q1s;
		logic [USER_W-1:0] user;
		e1tz_sync_t st;
		logic [1:0] bad;
		logic er;
	} e1tz_state_t;

	e1tz_state_t r;
	e1tz_state_t next_r;
	logic [PIN_N-1:0] pins;
	logic fn;
	logic tclk_rise;
	logic frs_rise;
	logic rclk_rise;
	logic rclk_fall;
	logic rai_upd;

	// Pins gathered for the three-stage synchroniser
	assign pins = {i_rx_frame15_marker, i_rx_frame13_marker, i_rx_crc_mode, i_rx_reset,
		i_rx_data, i_rx_bit_clk, i_tx_intl_bit_sync_in, i_tx_intl_bit_nonsync_in,
		i_tx_frame_sync_in, i_tx_bit_clk, i_scan_test_select};

	// Edge events taken from the second and third stages only
	assign fn = ~r.s2[P_SCAN];
	assign tclk_rise = r.s2[P_TCLK] & ~r.s3[P_TCLK];
	assign frs_rise = r.s2[P_FRS] & ~r.s3[P_FRS];
	assign rclk_rise = r.s2[P_RCLK] & ~r.s3[P_RCLK];
	assign rclk_fall = ~r.s2[P_RCLK] & r.s3[P_RCLK];

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_r = r;
		rai_upd = 1'b0;
		next_r.s1 = pins;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		if (fn) begin
			// Transmit: frame sync rise opens TS0 and presents bit 1
			if (frs_rise) begin
				next_r.tx_bit = BIT_FIRST;
				next_r.tx_ts = TS_ZERO;
				next_r.tx_active = 1'b1;
				if (r.tx_marker) begin
					next_r.tx_data = r.s2[P_D1S];
				end else begin
					next_r.tx_data = r.s2[P_D1N];
				end
			end else if (tclk_rise && r.tx_active) begin
				if (r.tx_ts == TS_ONE && r.tx_bit == BIT_FIRST) begin
					next_r.tx_marker = ~r.tx_marker;
				end
				next_r.tx_data = 1'b0;
				if (r.tx_bit == BIT_LAST) begin
					next_r.tx_bit = BIT_FIRST;
					next_r.tx_ts = r.tx_ts + TS_ONE;
				end else begin
					next_r.tx_bit = r.tx_bit + BIT_FIRST;
				end
			end

			// Receive: bit boundaries on the bit clock rise
			if (rclk_rise) begin
				if (r.rx_bit == BIT_LAST) begin
					next_r.rx_bit = BIT_FIRST;
					next_r.rx_ts = r.rx_ts + TS_ONE;
					if (r.rx_ts == TS_LAST) begin
						next_r.rx_sync_fr = ~r.rx_sync_fr;
					end
				end else begin
					next_r.rx_bit = r.rx_bit + BIT_FIRST;
				end
				next_r.ts0 = (next_r.rx_ts == TS_ZERO);
				next_r.ccr_n = !(next_r.rx_sync_fr && next_r.rx_ts == TS_ONE &&
					next_r.rx_bit == BIT_FIRST);
				if (next_r.rx_bit == BIT_LAST && next_r.rx_ts == TS_ZERO) begin
					next_r.ck8 = 1'b0;
				end else if (next_r.rx_bit == BIT_LAST && next_r.rx_ts == TS_MID) begin
					next_r.ck8 = 1'b1;
				end
				rai_upd = !next_r.rx_sync_fr && next_r.rx_ts == TS_ONE &&
					next_r.rx_bit == BIT_FIRST;
			end

			// Receive: data is latched on the bit clock fall
			if (rclk_fall) begin
				next_r.rx_shift = {r.rx_shift[5:0], r.s2[P_RD]};
				if (r.rx_ts == TS_ZERO && r.rx_bit == BIT_LAST) begin
					next_r.rx_word = {r.rx_shift, r.s2[P_RD]};
					next_r.rx_f13 = r.s2[P_F13];
					next_r.rx_f15 = r.s2[P_F15];
				end
				// Half a period after TS0: publish and check
				if (r.rx_ts == TS_ONE && r.rx_bit == BIT_FIRST) begin
					if (!r.rx_sync_fr) begin
						next_r.user = r.rx_word[USER_W-1:0];
						next_r.er = 1'b0;
						if (!r.s2[P_CRC]) begin
							next_r.q1n = r.rx_word[7];
						end else begin
							if (r.rx_f13) begin
								next_r.q1s = r.rx_word[7];
							end
							if (r.rx_f15) begin
								next_r.q1n = r.rx_word[7];
							end
						end
					end else begin
						if (!r.s2[P_CRC]) begin
							next_r.q1s = r.rx_word[7];
						end
						if (r.st == ST_IN) begin
							if (r.rx_word[6:0] != FAS_WORD) begin
								next_r.er = 1'b1;
								next_r.bad = r.bad + 2'h1;
								if (r.bad == BAD_LIMIT - 2'h1) begin
									next_r.st = ST_OUT;
									next_r.bad = 2'h0;
								end
							end else begin
								next_r.bad = 2'h0;
								next_r.er = 1'b0;
							end
						end
					end
				end
				// Receiver reset pin forces loss of alignment
				if (r.s2[P_RRST]) begin
					next_r.st = ST_OUT;
					next_r.bad = 2'h0;
				end
			end

			// Alignment found by the hunting logic
			if (i_rx_align_found && r.st == ST_OUT && !r.s2[P_RRST]) begin
				next_r.st = ST_IN;
				next_r.bad = 2'h0;
			end
		end
	end

	// Register with synchronous reset and clock enable
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			r <= '0;
			r.tx_bit <= BIT_FIRST;
			r.rx_bit <= BIT_FIRST;
			r.rx_sync_fr <= SYNC_FR_RST;
			r.ccr_n <= CCR_IDLE;
			r.ts0 <= TS0_RST;
			r.ck8 <= CK8_RST;
			r.st <= ST_OUT;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// Remote alarm
	// ****************************************************************
	e1tz_rx_alarm u_alarm (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_upd(rai_upd),
		.i_bit3(r.rx_word[5]),
		.i_in_sync(r.st == ST_IN),
		.o_rx_remote_alarm(o_rx_remote_alarm)
	);

	// Outputs straight from state
	assign o_scan_mode = r.s2[P_SCAN];
	assign o_tx_data = r.tx_data;
	assign o_tx_sync_frame_marker = r.tx_marker;
	assign o_rx_ts0_marker = r.ts0;
	assign o_rx_channel_reset_strobe_n = r.ccr_n;
	assign o_rx_eight_khz_clock = r.ck8;
	assign o_rx_intl_bit_nonsync = r.q1n;
	assign o_rx_intl_bit_sync = r.q1s;
	assign o_rx_user_bits = r.user;
	assign o_rx_sync_word_error = r.er;
	assign o_rx_in_sync = (r.st == ST_IN);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	property p_tx_nonsync;
		i_ce && fn && frs_rise && !r.tx_marker |=> o_tx_data == $past(r.s2[P_D1N]);
	endproperty
	a_tx_nonsync: assert property (p_tx_nonsync) else $error("non-sync bit 1 wrong");

	property p_tx_sync;
		i_ce && fn && frs_rise && r.tx_marker |=> o_tx_data == $past(r.s2[P_D1S]);
	endproperty
	a_tx_sync: assert property (p_tx_sync) else $error("sync bit 1 wrong");

	property p_marker;
		$changed(o_tx_sync_frame_marker) |-> $past(r.tx_ts) == TS_ONE &&
			$past(r.tx_bit) == BIT_FIRST;
	endproperty
	a_marker: assert property (p_marker) else $error("marker toggled off bit 1 of TS1");

	property p_ts0;
		o_rx_ts0_marker == (r.rx_ts == TS_ZERO);
	endproperty
	a_ts0: assert property (p_ts0) else $error("TS0 marker outside TS0");

	property p_ccr;
		!o_rx_channel_reset_strobe_n |-> r.rx_sync_fr && r.rx_ts == TS_ONE &&
			r.rx_bit == BIT_FIRST;
	endproperty
	a_ccr: assert property (p_ccr) else $error("channel reset strobe misplaced");

	property p_ck8;
		$changed(o_rx_eight_khz_clock) |-> r.rx_bit == BIT_LAST &&
			r.rx_ts == (o_rx_eight_khz_clock ? TS_MID : TS_ZERO);
	endproperty
	a_ck8: assert property (p_ck8) else $error("8 kHz clock edge misplaced");

	property p_oos;
		$fell(o_rx_in_sync) |-> $past(r.bad) == BAD_LIMIT - 2'h1 || $past(r.s2[P_RRST]);
	endproperty
	a_oos: assert property (p_oos) else $error("sync lost too early");

	property p_scan;
		r.s2[P_SCAN] |=> $stable(r.rx_ts) && $stable(r.tx_ts);
	endproperty
	a_scan: assert property (p_scan) else $error("timing moved in scan mode");
endmodule : e1tz_framer

// ### verification/e1tz_far_end.sv
// Far end model: bit clocks, frame sync, frame markers and received timeslot zero
`timescale 1ns/1ps
module e1tz_far_end
	import e1tz_pkg::*;
#(
	parameter int BIT = 16
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_bad_fas,
	input wire logic i_bit3,
	input wire logic i_bit1,
	output logic o_bit_clk,
	output logic o_frame_sync,
	output logic o_rx_data,
	output logic o_f13,
	output logic o_f15,
	output logic o_sync_fr,
	output logic [7:0] o_bit_no
);
	logic [7:0] nb;
	logic [7:0] word;
	logic next_sync;
	logic [3:0] fr;
	int ph;
	// ****************************************************************
	// Next bit number and the timeslot zero word of its frame
	// ****************************************************************
	assign nb = o_bit_no + 8'h01;
	assign next_sync = (nb == 8'h00) ^ o_sync_fr;
	assign word = next_sync ? {1'b1, FAS_WORD ^ {6'h00, i_bad_fas}} :
		{i_bit1, 1'b1, i_bit3, 5'h15};
	// ****************************************************************
	// Multiframe markers, held as levels over the whole frame
	// ****************************************************************
	assign o_f13 = fr == 4'hD;
	assign o_f15 = fr == 4'hF;
	// Clock rises at each bit start and falls halfway through the bit
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ph <= 0;
			o_bit_no <= 8'h00;
			o_bit_clk <= 1'b0;
			o_frame_sync <= 1'b1;
			o_rx_data <= 1'b0;
			o_sync_fr <= 1'b1;
			fr <= 4'h0;
		end else if (ph == BIT - 1) begin
			ph <= 0;
			o_bit_clk <= 1'b1;
			o_bit_no <= nb;
			o_frame_sync <= nb < 8'h08;
			o_rx_data <= nb < 8'h08 ? word[3'h7 - nb[2:0]] : 1'b0;
			if (nb == 8'h00) begin
				o_sync_fr <= ~o_sync_fr;
				fr <= fr + 4'h1;
			end
		end else begin
			ph <= ph + 1;
			if (ph == BIT / 2 - 1) o_bit_clk <= 1'b0;
		end
	end
endmodule : e1tz_far_end

// ### verification/tb_top.sv
// Self-checking bench for the timeslot zero framer
`timescale 1ns/1ps
module tb_top;
	import e1tz_pkg::*;
	localparam int BIT = 8;
	localparam int FRAME = 256 * BIT;
	logic i_clk_sys, i_rst_n, scan, align, bad_fas, bit3, intl_n, intl_s, crc, b1;
	logic bclk, fsync, rdata, f13, f15, sfr, smode, txd, mark, ts0, ccr_n, ck8, qn, qs, err, ins, rx_remote_alarm;
	logic [7:0] bno;
	logic [5:0] user;
	int n_fail, checks_done, cyc, n;
	e1tz_far_end #(.BIT(BIT)) e1tz_far_end_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_bad_fas(bad_fas), .i_bit3(bit3), .i_bit1(b1), .o_bit_clk(bclk), .o_frame_sync(fsync),
		.o_rx_data(rdata), .o_f13(f13), .o_f15(f15), .o_sync_fr(sfr), .o_bit_no(bno));
	e1tz_framer e1tz_framer_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(1'b1),
		.i_scan_test_select(scan), .i_tx_bit_clk(bclk), .i_tx_frame_sync_in(fsync),
		.i_tx_intl_bit_nonsync_in(intl_n), .i_tx_intl_bit_sync_in(intl_s),
		.i_rx_bit_clk(bclk), .i_rx_data(rdata), .i_rx_reset(1'b0), .i_rx_crc_mode(crc),
		.i_rx_frame13_marker(f13), .i_rx_frame15_marker(f15), .i_rx_align_found(align),
		.o_scan_mode(smode), .o_tx_data(txd), .o_tx_sync_frame_marker(mark),
		.o_rx_ts0_marker(ts0), .o_rx_channel_reset_strobe_n(ccr_n),
		.o_rx_eight_khz_clock(ck8), .o_rx_intl_bit_nonsync(qn), .o_rx_intl_bit_sync(qs),
		.o_rx_user_bits(user), .o_rx_sync_word_error(err), .o_rx_in_sync(ins),
		.o_rx_remote_alarm(rx_remote_alarm));
	// ****************************************************************
	// Clock, timeout and shared helpers
	// ****************************************************************
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	// Hang guard, the planned run is about 78000 cycles
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic tick();
		@(posedge i_clk_sys);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h", $time, msg, got);
		end
	endtask : chk
	task automatic chkn(input int got, input int exp, input string msg);
		checks_done++;
		if (got != exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %0d", $time, msg, got);
		end
	endtask : chkn
	function automatic logic sig(input int k);
		case (k)
			0: return ts0;
			1: return ccr_n;
			2: return ck8;
			default: return rx_remote_alarm;
		endcase
	endfunction : sig
	// Count cycles until the chosen output reaches a level
	task automatic wait_lvl(input int k, input logic lvl);
		n = 0;
		while (sig(k) !== lvl && n < 3 * FRAME) begin
			tick();
			n++;
		end
	endtask : wait_lvl
	// Wait for a bit number of the far end, then to the middle of that bit
	task automatic wait_bno(input logic [7:0] b);
		while (bno !== b) tick();
		repeat (BIT / 2) tick();
	endtask : wait_bno
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_tx();
		logic prev;
		prev = 1'b0;
		for (int f = 0; f < 3; f++) begin
			wait_bno(8'h64);
			intl_n <= f[0];
			intl_s <= ~f[0];
			wait_bno(8'h00);
			chk(txd, mark ? intl_s : intl_n, "tx intl bit");
			if (f > 0) chk(mark, !prev, "marker alternation");
			prev = mark;
			wait_bno(8'h03);
			chk(txd, 1'b0, "tx outside bit 1");
			wait_bno(8'h08);
			chk(mark, prev, "marker through bit 1 ts1");
			wait_bno(8'h09);
			chk(mark, !prev, "marker after bit 1 ts1");
		end
	endtask : t_tx
	task automatic t_rx_timing();
		wait_lvl(0, 1'b0);
		wait_lvl(0, 1'b1);
		wait_lvl(2, 1'b0);
		chkn(n, 7 * BIT, "8k fall after ts0 start");
		wait_lvl(2, 1'b1);
		chkn(n, 128 * BIT, "8k low span");
		wait_lvl(0, 1'b1);
		wait_lvl(0, 1'b0);
		chkn(n, 8 * BIT, "ts0 marker width");
		wait_lvl(0, 1'b1);
		chkn(n, 248 * BIT, "ts0 marker low span");
		wait_lvl(1, 1'b0);
		chk(bno == 8'h08 && sfr, 1'b1, "strobe place");
		wait_lvl(1, 1'b1);
		chkn(n, BIT, "strobe width");
		wait_lvl(1, 1'b0);
		chkn(n, 2 * FRAME - BIT, "strobe spacing");
	endtask : t_rx_timing
	task automatic t_alarm();
		int e;
		logic pe;
		@(posedge i_clk_sys);
		align <= 1'b1;
		@(posedge i_clk_sys);
		align <= 1'b0;
		tick();
		chk(ins, 1'b1, "in sync");
		wait_lvl(3, 1'b1);
		chk(bno == 8'h08 && !sfr, 1'b1, "alarm change place");
		chk(n > FRAME, 1'b1, "alarm after two bits");
		chk(rx_remote_alarm, 1'b1, "alarm raised");
		chk(user, {bit3, 5'h15}, "user bits");
		chk({qn, qs}, 2'b11, "rx intl bits");
		@(posedge i_clk_sys);
		bad_fas <= 1'b1;
		e = 0;
		pe = 1'b0;
		n = 0;
		while (ins === 1'b1 && n < 8 * FRAME) begin
			tick();
			if (err === 1'b1 && !pe) e++;
			pe = err;
			n++;
		end
		chkn(e, 3, "errors before sync loss");
		repeat (FRAME) tick();
		chk(rx_remote_alarm, 1'b0, "alarm forced low");
		@(posedge i_clk_sys);
		bad_fas <= 1'b0;
		repeat (2 * FRAME) tick();
		chk(rx_remote_alarm, 1'b0, "alarm held low");
	endtask : t_alarm
	// Checksum mode takes bit 1 only from frames 13 and 15, both sent low here
	task automatic t_crc();
		@(posedge i_clk_sys);
		crc <= 1'b1;
		b1 <= 1'b0;
		repeat (16 * FRAME) tick();
		chk({qn, qs}, 2'b00, "checksum mode intl bits");
		@(posedge i_clk_sys);
		crc <= 1'b0;
		repeat (2 * FRAME) tick();
		chk({qn, qs}, 2'b01, "alternate frame intl bits");
	endtask : t_crc
	task automatic t_scan();
		logic m;
		@(posedge i_clk_sys);
		scan <= 1'b1;
		repeat (4) tick();
		chk(smode, 1'b1, "scan mode");
		m = mark;
		repeat (FRAME) tick();
		chk(mark, m, "frozen in scan");
		@(posedge i_clk_sys);
		scan <= 1'b0;
		repeat (4) tick();
		chk(smode, 1'b0, "normal mode");
	endtask : t_scan
	task automatic give_verdict();
		$display("checks %0d, failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{i_rst_n, scan, align, bad_fas, intl_n, intl_s, crc} = 7'h00;
		bit3 = 1'b1;
		b1 = 1'b1;
		{n_fail, checks_done, cyc} = 0;
		repeat (8) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		#1;
		chk({ts0, ccr_n, ck8, rx_remote_alarm, txd}, 5'h1C, "reset levels");
		t_tx();
		t_rx_timing();
		t_alarm();
		t_crc();
		t_scan();
		give_verdict();
	end
endmodule : tb_top
